// ===== core/ctc_cfg.svh
`ifndef CTC_CFG_SVH
`define CTC_CFG_SVH

// ------------------------------------------
// Bus geometry
// ------------------------------------------
`define CTC_AW 16
`define CTC_DW 8
`define CTC_CW 24
`define CTC_NBYTE 3
`define CTC_NEV 5
`define CTC_PRE_W 3

// ------------------------------------------
// Register addresses
// ------------------------------------------
`define CTC_ADDR_CN1 16'ha100
`define CTC_ADDR_CN2 16'ha101
`define CTC_ADDR_CNT_L 16'ha102
`define CTC_ADDR_CNT_M 16'ha103
`define CTC_ADDR_CNT_H 16'ha104
`define CTC_ADDR_RL_L 16'ha105
`define CTC_ADDR_CMP_L 16'ha018
`define CTC_ADDR_STAT 16'ha108
`define CTC_ADDR_CLR 16'ha109

// ------------------------------------------
// Field positions
// ------------------------------------------
`define CTC_EV_HI 7
`define CTC_EV_LO 3
`define CTC_WG_BIT 2
`define CTC_DIV_HI 1
`define CTC_DIV_LO 0

// ------------------------------------------
// Reset values and limits
// ------------------------------------------
`define CTC_RST_DIV 2'h0
`define CTC_RST_CN2 8'h00
`define CTC_RST_WORD 24'h000000
`define CTC_CNT_MAX 24'hffffff

`endif

// ===== core/ctc_pkg.sv
package ctc_pkg;

    // Count tick source
    typedef enum logic [1:0] {
        CTC_DIV8 = 2'b00,
        CTC_DIV4 = 2'b01,
        CTC_DIV2 = 2'b10,
        CTC_DIV1 = 2'b11
    } ctc_div_type;

    // The five event sources, in register bit order 7..3
    typedef struct packed {
        logic cmp2;
        logic cmp1;
        logic ovf24;
        logic ovf16;
        logic ovf8;
    } ctc_evt_type;

    // Second control register, same bit order as stored
    typedef struct packed {
        ctc_evt_type en;
        logic init_rl;
        logic run;
        logic autold;
    } ctc_ctl_type;

endpackage

// ===== core/ctc_timer.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "ctc_cfg.svh"

module ctc_timer (
    input wire logic i_ref_clk,                   // System clock
    input wire logic i_sys_rst,                   // Async reset, active high
    input wire logic [`CTC_AW-1:0] i_addr,        // Register address
    input wire logic [`CTC_DW-1:0] i_wdata,       // Write data
    input wire logic i_wr,                        // Write strobe
    input wire logic i_rd,                        // Read strobe
    output logic [`CTC_DW-1:0] o_rdata,           // Read data, cycle after read
    output logic o_irq                            // Timer interrupt, level
);

    // ------------------------------------------
    // State
    // ------------------------------------------
    ctc_pkg::ctc_div_type div_q;
    ctc_pkg::ctc_ctl_type ctl_q;
    ctc_pkg::ctc_evt_type flg_q;
    ctc_pkg::ctc_evt_type evt;
    logic [`CTC_PRE_W-1:0] pre_q;
    logic [`CTC_CW-1:0] cnt_q;
    logic [`CTC_CW-1:0] cnt_d;
    logic [`CTC_CW-1:0] rl_q;
    logic [`CTC_CW-1:0] cmp_q;
    logic [`CTC_DW-1:0] rdata_q;
    logic [`CTC_DW-1:0] rdata_d;
    logic irq_q;
    logic tick;
    logic cnt_upd;
    logic wr_cn1;
    logic wr_cn2;
    logic wr_cnt_l;
    logic wr_clr;
    logic [`CTC_NEV-1:0] wmask;
    logic [`CTC_NEV-1:0] clr_hit;
    logic [`CTC_NEV-1:0] ev_vec;
    logic [`CTC_NEV-1:0] en_vec;

    // ------------------------------------------
    // Address decode
    // ------------------------------------------

    // Write hits; the slave never stalls so every strobe is taken at once
    assign wr_cn1 = i_wr && (i_addr == `CTC_ADDR_CN1);
    assign wr_cn2 = i_wr && (i_addr == `CTC_ADDR_CN2);
    assign wr_cnt_l = i_wr && (i_addr == `CTC_ADDR_CNT_L);
    assign wr_clr = i_wr && (i_addr == `CTC_ADDR_CLR);
    assign wmask = i_wdata[`CTC_EV_HI:`CTC_EV_LO];

    // ------------------------------------------
    // Control registers
    // ------------------------------------------

    // Divider select, held when the write gate is set
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_q <= ctc_pkg::ctc_div_type'(`CTC_RST_DIV);
        end else if (wr_cn1 && !i_wdata[`CTC_WG_BIT]) begin
            div_q <= ctc_pkg::ctc_div_type'(i_wdata[`CTC_DIV_HI:`CTC_DIV_LO]);
        end
    end

    // Enables, init source, run and mode; plain read-write byte
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl_q <= ctc_pkg::ctc_ctl_type'(`CTC_RST_CN2);
        end else if (wr_cn2) begin
            ctl_q <= ctc_pkg::ctc_ctl_type'(i_wdata);
        end
    end

    // Reload and compare-one bytes, one pair of byte lanes per index
    genvar b;
    generate
        for (b = 0; b < `CTC_NBYTE; b++) begin : g_byte
            always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    rl_q[b*8 +: 8] <= 8'(`CTC_RST_WORD >> (b*8));
                end else if (i_wr && (i_addr == `CTC_ADDR_RL_L + `CTC_AW'(b))) begin
                    rl_q[b*8 +: 8] <= i_wdata;
                end
            end
            always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    cmp_q[b*8 +: 8] <= 8'(`CTC_RST_WORD >> (b*8));
                end else if (i_wr && (i_addr == `CTC_ADDR_CMP_L + `CTC_AW'(b))) begin
                    cmp_q[b*8 +: 8] <= i_wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------
    // Prescaler
    // ------------------------------------------

    // Free-running divider; changing the select mid-period may give one short tick
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Tick select from the divider phase
    always_comb begin
        case (div_q)
            ctc_pkg::CTC_DIV8: tick = &pre_q;
            ctc_pkg::CTC_DIV4: tick = &pre_q[1:0];
            ctc_pkg::CTC_DIV2: tick = pre_q[0];
            ctc_pkg::CTC_DIV1: tick = 1'b1;
            default: tick = 1'b1;
        endcase
    end

    // ------------------------------------------
    // Counter
    // ------------------------------------------

    // Next count and the events it raises; an init write beats a tick
    always_comb begin
        cnt_d = cnt_q;
        cnt_upd = 1'b0;
        evt = '0;
        if (wr_cnt_l) begin
            cnt_upd = 1'b1;
            cnt_d = ctl_q.init_rl ? rl_q : '0;
        end else if (ctl_q.run && tick) begin
            cnt_upd = 1'b1;
            if (cnt_q == `CTC_CNT_MAX) begin
                cnt_d = ctl_q.autold ? rl_q : '0;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
            evt.ovf24 = (cnt_q == `CTC_CNT_MAX);
            evt.ovf16 = &cnt_q[15:0];
            evt.ovf8 = &cnt_q[7:0];
        end
        // Matches look at the new value, so a stopped counter cannot refire
        evt.cmp1 = cnt_upd && (cnt_d == cmp_q);
        evt.cmp2 = cnt_upd && !ctl_q.autold && (cnt_d == rl_q);
    end

    // Count register; middle and high writes have no path here
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------
    // Flags and interrupt
    // ------------------------------------------

    assign ev_vec = evt;
    assign en_vec = ctl_q.en;

    // Clear by writing 0 in control one, or 1 in the clear register
    assign clr_hit = ({`CTC_NEV{wr_cn1}} & ~wmask) | ({`CTC_NEV{wr_clr}} & wmask);

    // Sticky flags; a set in the same cycle as a clear wins
    genvar f;
    generate
        for (f = 0; f < `CTC_NEV; f++) begin : g_flag
            always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    flg_q[f] <= 1'b0;
                end else if (ev_vec[f] && en_vec[f]) begin
                    flg_q[f] <= 1'b1;
                end else if (clr_hit[f]) begin
                    flg_q[f] <= 1'b0;
                end
            end
        end
    endgenerate

    // Registered interrupt, one cycle behind the flags
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flg_q & ctl_q.en);
        end
    end

    // ------------------------------------------
    // Read path
    // ------------------------------------------

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_d = '0;
        case (i_addr)
            `CTC_ADDR_CN1: rdata_d = {flg_q, 1'b0, div_q};
            `CTC_ADDR_CN2: rdata_d = ctl_q;
            `CTC_ADDR_CNT_L: rdata_d = cnt_q[7:0];
            `CTC_ADDR_CNT_M: rdata_d = cnt_q[15:8];
            `CTC_ADDR_CNT_H: rdata_d = cnt_q[23:16];
            `CTC_ADDR_RL_L: rdata_d = rl_q[7:0];
            `CTC_ADDR_RL_L + 16'h0001: rdata_d = rl_q[15:8];
            `CTC_ADDR_RL_L + 16'h0002: rdata_d = rl_q[23:16];
            `CTC_ADDR_CMP_L: rdata_d = cmp_q[7:0];
            `CTC_ADDR_CMP_L + 16'h0001: rdata_d = cmp_q[15:8];
            `CTC_ADDR_CMP_L + 16'h0002: rdata_d = cmp_q[23:16];
            `CTC_ADDR_STAT: rdata_d = {flg_q, 3'h0};
            default: rdata_d = '0;
        endcase
    end

    // Data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= i_rd ? rdata_d : '0;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;

endmodule

// ===== tb/ctc_timer_properties.sv
`timescale 1ns/1ps
`include "ctc_cfg.svh"
// ------------------------------------------
// Port-level checks of the timer
// ------------------------------------------
module ctc_timer_chk (
    input wire logic i_ref_clk,             // System clock
    input wire logic i_sys_rst,             // Async reset, active high
    input wire logic [`CTC_AW-1:0] i_addr,  // Register address
    input wire logic [`CTC_DW-1:0] i_wdata, // Write data
    input wire logic i_wr,                  // Write strobe
    input wire logic i_rd,                  // Read strobe
    input wire logic [`CTC_DW-1:0] o_rdata, // Read data
    input wire logic o_irq                  // Timer interrupt
);
    // One domain only, so clock and reset are given once
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    idle_rdata_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    gate_bit_a: assert property ($past(i_rd) && $past(i_addr) == `CTC_ADDR_CN1 |-> o_rdata[2] == 1'b0)
        else $error("write gate bit read back as one");
    clr_read_a: assert property ($past(i_rd) && $past(i_addr) == `CTC_ADDR_CLR |-> o_rdata == 8'h00)
        else $error("clear register did not read as zero");
    // Dropping every enable must drop the interrupt two edges later
    en_off_a: assert property (i_wr && i_addr == `CTC_ADDR_CN2 && i_wdata[7:3] == 5'h00 |-> ##2 !o_irq)
        else $error("interrupt stayed up with all enables off");
    // A flag only goes away through a software write
    irq_sticky_a: assert property ($fell(o_irq) |-> $past(i_wr, 2))
        else $error("interrupt fell with no write before it");
    div_keep_a: assert property (i_wr && i_addr == `CTC_ADDR_CN1 && !i_wdata[2] ##1 !i_wr ##1
        i_rd && i_addr == `CTC_ADDR_CN1 |-> ##1 o_rdata[1:0] == $past(i_wdata[1:0], 3))
        else $error("divider select not written with gate low");
    reload_rw_a: assert property (i_wr && i_addr == `CTC_ADDR_RL_L ##1 !i_wr ##1
        i_rd && i_addr == `CTC_ADDR_RL_L |-> ##1 o_rdata == $past(i_wdata, 3))
        else $error("reload low byte did not read back");
    ctl2_rw_a: assert property (i_wr && i_addr == `CTC_ADDR_CN2 ##1 !i_wr ##1
        i_rd && i_addr == `CTC_ADDR_CN2 |-> ##1 o_rdata == $past(i_wdata, 3))
        else $error("second control register did not read back");
endmodule

bind ctc_timer ctc_timer_chk i_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));

// ===== tb/ctc_timer_tb.sv
`timescale 1ns/1ps
`include "ctc_cfg.svh"
module ctc_timer_tb;
    logic i_ref_clk;
    logic i_sys_rst;
    logic [15:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic o_irq;
    int bad_count;
    int cmp_count;
    logic [15:0] zero_addr [9] = '{`CTC_ADDR_CN1, `CTC_ADDR_CN2, `CTC_ADDR_CNT_L, `CTC_ADDR_CNT_H,
        `CTC_ADDR_RL_L, `CTC_ADDR_CMP_L, `CTC_ADDR_STAT, `CTC_ADDR_CLR, 16'ha10f};

    ctc_timer i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));

    // ------------------------------------------
    // Clock and access tasks
    // ------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Idle edge after each strobe, so no strobe is driven twice in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
        @(posedge i_ref_clk);
    endtask

    // Interrupt level, looked at off the edge so that it has settled
    task automatic irq_is(input logic exp);
        #1;
        check({7'h00, o_irq}, {7'h00, exp});
        @(posedge i_ref_clk);
    endtask

    // Count runs for exactly k+2 edges between the two writes
    task automatic run(input logic [7:0] on, input logic [7:0] off, input int k);
        wr(`CTC_ADDR_CN2, on);
        repeat (k) @(posedge i_ref_clk);
        wr(`CTC_ADDR_CN2, off);
    endtask

    task automatic test_done;
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------
    // Tests
    // ------------------------------------------
    // Watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (8000) @(posedge i_ref_clk);
        bad_count++;
        test_done;
    end

    initial begin
        i_sys_rst <= 1'b1;
        i_addr <= 16'h0000;
        i_wdata <= 8'h00;
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (20) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_ref_clk);
        foreach (zero_addr[i]) rd(zero_addr[i], 8'h00);
        $display("test reset values done");
        wr(`CTC_ADDR_CN1, 8'hfb);
        rd(`CTC_ADDR_CN1, 8'h03);
        // Gate set: the zero divider carried by this write must not land
        wr(`CTC_ADDR_CN1, 8'hfc);
        rd(`CTC_ADDR_CN1, 8'h03);
        $display("test write gate done");
        // Window of 64 edges gives 64 divided by the tick period
        for (int d = 0; d < 4; d++) begin
            wr(`CTC_ADDR_CN1, 8'(d));
            wr(`CTC_ADDR_CN2, 8'h00);
            wr(`CTC_ADDR_CNT_L, 8'h00);
            run(8'h02, 8'h00, 62);
            rd(`CTC_ADDR_CNT_L, 8'h40 >> (3 - d));
            repeat (5) @(posedge i_ref_clk);
            rd(`CTC_ADDR_CNT_L, 8'h40 >> (3 - d));
        end
        $display("test divider done");
        wr(`CTC_ADDR_RL_L, 8'h05);
        wr(`CTC_ADDR_CMP_L, 8'h09);
        wr(`CTC_ADDR_CN2, 8'hc0);
        wr(`CTC_ADDR_CNT_L, 8'h00);
        run(8'hc2, 8'hc0, 10);
        rd(`CTC_ADDR_STAT, 8'hc0);
        irq_is(1'b1);
        wr(`CTC_ADDR_CLR, 8'hc0);
        rd(`CTC_ADDR_STAT, 8'h00);
        irq_is(1'b0);
        $display("test compare done");
        wr(`CTC_ADDR_RL_L + 16'h2, 8'hff);
        wr(`CTC_ADDR_RL_L + 16'h1, 8'hff);
        wr(`CTC_ADDR_RL_L, 8'hf8);
        rd(`CTC_ADDR_RL_L, 8'hf8);
        wr(`CTC_ADDR_CN2, 8'h04);
        wr(`CTC_ADDR_CNT_L, 8'h00);
        rd(`CTC_ADDR_CNT_H, 8'hff);
        run(8'h06, 8'h04, 8);
        rd(`CTC_ADDR_CNT_L, 8'h02);
        rd(`CTC_ADDR_CNT_H, 8'h00);
        rd(`CTC_ADDR_STAT, 8'h00);
        irq_is(1'b0);
        $display("test free run done");
        wr(`CTC_ADDR_RL_L, 8'hf0);
        wr(`CTC_ADDR_CN2, 8'h3c);
        wr(`CTC_ADDR_CNT_L, 8'h00);
        wr(`CTC_ADDR_CNT_M, 8'h00);
        rd(`CTC_ADDR_CNT_M, 8'hff);
        run(8'h3f, 8'h3d, 18);
        rd(`CTC_ADDR_CN2, 8'h3d);
        rd(`CTC_ADDR_CNT_L, 8'hf4);
        rd(`CTC_ADDR_STAT, 8'h38);
        wr(`CTC_ADDR_CN1, 8'hf3);
        rd(`CTC_ADDR_STAT, 8'h30);
        irq_is(1'b1);
        wr(`CTC_ADDR_CLR, 8'h30);
        rd(`CTC_ADDR_STAT, 8'h00);
        irq_is(1'b0);
        $display("test auto reload done");
        // A low byte rollover alone must raise only the eight-bit flag
        wr(`CTC_ADDR_RL_L + 16'h2, 8'h00);
        wr(`CTC_ADDR_RL_L + 16'h1, 8'h00);
        wr(`CTC_ADDR_RL_L, 8'hfe);
        wr(`CTC_ADDR_CN2, 8'h3c);
        wr(`CTC_ADDR_CNT_L, 8'h00);
        run(8'h3e, 8'h3c, 0);
        rd(`CTC_ADDR_CNT_M, 8'h01);
        rd(`CTC_ADDR_STAT, 8'h08);
        irq_is(1'b1);
        wr(`CTC_ADDR_CLR, 8'h08);
        irq_is(1'b0);
        $display("test byte rollover done");
        test_done;
    end
endmodule
